/* File: half_bridge_model.sv */
// Model of the external half-bridge legs driven by the responder.
// Assumes registered gate outputs and one clock shared with the bench.
`timescale 1ns/1ps
module half_bridge_model #(
  parameter logic [2:0] HS_CMD = 3'h1,
  parameter logic [2:0] LS_CMD = 3'h2
) (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Gate drive.
  input  wire logic [2:0] gate_hs,
  input  wire logic [2:0] gate_ls,
  output logic [2:0]      gate_hs_req,
  output logic [2:0]      gate_ls_req,
  output int              shoot_cnt
);
  // ==========================================================
  // Commutation commands never turn on both switches of one leg.
  assign gate_hs_req = HS_CMD;
  assign gate_ls_req = LS_CMD;
  // Counts edges at which some leg conducts through both switches.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shoot_cnt <= 0;
    end else if ((gate_hs & gate_ls) != 3'h0) begin
      shoot_cnt <= shoot_cnt + 1;
    end
  end
endmodule

/* File: lock_fault_pkg.sv */
// Constants, mode codes and timing figures for the lock fault responder.
// Assumes one 25 MHz clock and an APB master with 32-bit data.
// Operation
// - Lock-current latched 000x: all gates off, pin low
// - Lock-current latched 001x: low sides on, pin low
// - Lock-current retry 010x: gates off, auto resume
// - Lock-current retry 011x: low sides on, resume
// - Lock-current 1000: report only, gates keep running
// - Lock-current 1xx1: events fully ignored
// - Any enabled stall condition raises stall event while motor_running
// - Each stall detector own enable; shared retry delay
// - Stall latched: off or low sides, clear needed
// - Stall retry: off or low sides, auto resume
// - Stall retry: status set, cleared at expiry
// - Stall 1000: report only, clear needed
// - Stall 1xx1: no action at all
// - Overspeed above threshold raises stall event
// - Back-EMF mismatch above threshold raises stall
// - Phase current low 500 ms in open loop
// - Measured back-EMF below threshold sets fault
// - Clear command resumes latched fault once gone
package lock_fault_pkg;
  // ==========================================================
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // Modes, enables, retry, clear.
  localparam logic [7:0] OFS_THR0   = 8'h04;  // Overspeed and back-EMF error limits.
  localparam logic [7:0] OFS_THR1   = 8'h08;  // Open phase and measure limits.
  localparam logic [7:0] OFS_STATUS = 8'h0C;  // Fault status, read only.
  // ==========================================================
  // Control register fields.
  localparam int CTL_OC_MODE_LSB  = 0;
  localparam int CTL_ST_MODE_LSB  = 4;
  localparam int CTL_EN_SPEED     = 8;
  localparam int CTL_EN_BEMF      = 9;
  localparam int CTL_EN_OPEN      = 10;
  localparam int CTL_RETRY_LSB    = 12;
  localparam int CTL_CLEAR        = 31;
  localparam int THR_LO_LSB       = 0;   // Lower limit field of a threshold word.
  localparam int THR_HI_LSB       = 16;  // Upper limit field of a threshold word.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ==========================================================
  // Mode codes (upper bits classify, bit 1 picks low-side braking).
  localparam logic [1:0] CLS_LATCH  = 2'h0;
  localparam logic [1:0] CLS_RETRY  = 2'h1;
  localparam logic [3:0] MODE_REPORT = 4'h8;
  localparam int MODE_BRAKE_BIT = 1;
  // ==========================================================
  // Timing.
  localparam int CLK_HZ          = 25_000_000;
  localparam int OPEN_PHASE_MS   = 500;
  localparam longint OPEN_CYC_L  = (longint'(CLK_HZ) * OPEN_PHASE_MS + 999) / 1000;
  localparam int OPEN_CYCLES     = int'(OPEN_CYC_L);
  localparam int RETRY_BASE_MS   = 100;   // Retry step per select count.
  localparam int RETRY_BASE_CYC  = int'((longint'(CLK_HZ) * RETRY_BASE_MS) / 1000);
  // ==========================================================
  // Types.
  typedef enum logic [1:0] {ACT_NONE, ACT_REPORT, ACT_LATCH, ACT_RETRY} action_t;
  typedef enum logic [1:0] {ST_IDLE, ST_LATCHED, ST_RETRY, ST_REPORT} resp_state_t;
endpackage

/* File: lock_fault_responder.sv */
// Lock current-limit and motor stall fault responder with APB registers.
// Assumes detector inputs synchronous to pclk and gate commands from control logic.
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module lock_fault_responder
  import lock_fault_pkg::*;
#(
  parameter int SPEED_W  = 16,
  parameter int OPEN_CYC = OPEN_CYCLES,
  parameter int RETRY_CYC = RETRY_BASE_CYC
) (
  // Clock and reset.
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic [31:0]             prdata,
  // Measurements.
  input  wire logic               overcurrent_event,
  input  wire logic [SPEED_W-1:0] speed_meas,
  input  wire logic [SPEED_W-1:0] backemf_est,
  input  wire logic [SPEED_W-1:0] backemf_expected,
  input  wire logic [2:0]         phase_current_low,
  input  wire logic               open_loop,
  input  wire logic               motor_running,
  input  wire logic               param_est_active,
  input  wire logic [SPEED_W-1:0] backemf_measured,
  // Gate drive.
  input  wire logic [2:0]         gate_hs_req,
  input  wire logic [2:0]         gate_ls_req,
  output logic [2:0]              gate_hs,
  output logic [2:0]              gate_ls,
  output logic                    fault_out_n
);

  // ==========================================================
  // Mode decode, used for both fault sources.
  function automatic action_t decode_mode(input logic [3:0] m);
    if (m[3:2] == CLS_LATCH) decode_mode = ACT_LATCH;
    else if (m[3:2] == CLS_RETRY) decode_mode = ACT_RETRY;
    else if (m == MODE_REPORT) decode_mode = ACT_REPORT;
    else decode_mode = ACT_NONE;  // Codes 1xx1 and undefined codes ignore.
  endfunction

  // ==========================================================
  // Registers.
  logic [31:0] ctrl_ff, nxt_ctrl;          // Control word.
  logic [31:0] thr0_ff, nxt_thr0;          // Speed and back-EMF limits.
  logic [31:0] thr1_ff, nxt_thr1;          // Open phase and measure limits.
  logic        clear_fault_cmd;            // One-cycle clear pulse.
  logic        wr_en;                      // Write access edge.

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;  // Zero wait states.
  assign pslverr = 1'b0;
  assign clear_fault_cmd = wr_en && (paddr == OFS_CTRL) && pwdata[CTL_CLEAR];

  // Next register values.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_thr0 = thr0_ff;
    nxt_thr1 = thr1_ff;
    if (wr_en) begin
      unique case (paddr)
        OFS_CTRL: nxt_ctrl = {1'b0, pwdata[30:0]};  // Clear bit is self clearing.
        OFS_THR0: nxt_thr0 = pwdata;
        OFS_THR1: nxt_thr1 = pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
      thr0_ff <= '0;
      thr1_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      thr0_ff <= nxt_thr0;
      thr1_ff <= nxt_thr1;
    end
  end

  // Field views.
  logic [3:0]         overcurrent_lock_response_sel;
  logic [3:0]         stall_response_sel;
  logic [3:0]         retry_delay_sel;
  logic [SPEED_W-1:0] overspeed_threshold;
  logic [SPEED_W-1:0] backemf_error_threshold;
  logic [SPEED_W-1:0] open_phase_current_threshold;
  logic [SPEED_W-1:0] backemf_measure_threshold;
  assign overcurrent_lock_response_sel = ctrl_ff[CTL_OC_MODE_LSB +: 4];
  assign stall_response_sel = ctrl_ff[CTL_ST_MODE_LSB +: 4];
  assign retry_delay_sel = ctrl_ff[CTL_RETRY_LSB +: 4];
  assign overspeed_threshold = thr0_ff[THR_LO_LSB +: SPEED_W];
  assign backemf_error_threshold = thr0_ff[THR_HI_LSB +: SPEED_W];
  assign open_phase_current_threshold = thr1_ff[THR_LO_LSB +: SPEED_W];  // Reported only.
  assign backemf_measure_threshold = thr1_ff[THR_HI_LSB +: SPEED_W];

  // ==========================================================
  // Detectors.
  logic overspeed_detect, backemf_mismatch_detect, open_phase_detect;
  logic [SPEED_W-1:0] bemf_diff;
  logic [31:0] open_cnt_ff, nxt_open_cnt;
  logic param_est_backemf_fault, nxt_pebf;
  logic pebf_ff;

  assign bemf_diff = (backemf_est > backemf_expected) ? backemf_est - backemf_expected
                                                      : backemf_expected - backemf_est;
  assign overspeed_detect = ctrl_ff[CTL_EN_SPEED] &&
                            (speed_meas > overspeed_threshold);
  assign backemf_mismatch_detect = ctrl_ff[CTL_EN_BEMF] && motor_running &&
                                   (bemf_diff > backemf_error_threshold);
  assign open_phase_detect = ctrl_ff[CTL_EN_OPEN] &&
                             (open_cnt_ff >= 32'(OPEN_CYC));

  // Open phase timer counts while any phase reads low in open loop.
  always_comb begin
    nxt_open_cnt = '0;
    if (ctrl_ff[CTL_EN_OPEN] && open_loop && |phase_current_low) begin
      nxt_open_cnt = (open_cnt_ff >= 32'(OPEN_CYC)) ? open_cnt_ff : open_cnt_ff + 32'h1;
    end
    nxt_pebf = pebf_ff;
    if (param_est_active && (backemf_measured < backemf_measure_threshold)) begin
      nxt_pebf = 1'b1;  // Set wins over clear.
    end else if (clear_fault_cmd) begin
      nxt_pebf = 1'b0;
    end
  end
  assign param_est_backemf_fault = pebf_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_cnt_ff <= '0;
      pebf_ff <= 1'b0;
    end else begin
      open_cnt_ff <= nxt_open_cnt;
      pebf_ff <= nxt_pebf;
    end
  end

  logic stall_event;
  assign stall_event = motor_running &&
                       (overspeed_detect || backemf_mismatch_detect || open_phase_detect);

  // ==========================================================
  // Two response engines: index 0 lock current, index 1 stall.
  resp_state_t st_ff [2];
  resp_state_t nxt_st [2];
  logic [31:0] rcnt_ff [2];
  logic [31:0] nxt_rcnt [2];
  logic [1:0]  cond;
  logic [3:0]  mode [2];
  logic [31:0] retry_len;
  logic [1:0]  brake;  // Low-side braking requested per engine.
  logic [1:0]  off;    // Gates off per engine.
  logic [1:0]  flag;   // Status shown per engine.

  assign cond[0] = overcurrent_event;
  assign cond[1] = stall_event;
  assign mode[0] = overcurrent_lock_response_sel;
  assign mode[1] = stall_response_sel;
  assign retry_len = 32'(RETRY_CYC) * ({28'h0, retry_delay_sel} + 32'h1);

  for (genvar g = 0; g < 2; g++) begin : g_eng
    // Next state of one engine.
    always_comb begin
      nxt_st[g] = st_ff[g];
      nxt_rcnt[g] = rcnt_ff[g];
      unique case (st_ff[g])
        ST_IDLE: begin
          if (cond[g]) begin
            unique case (decode_mode(mode[g]))
              ACT_LATCH: nxt_st[g] = ST_LATCHED;
              ACT_RETRY: begin
                nxt_st[g] = ST_RETRY;
                nxt_rcnt[g] = '0;
              end
              ACT_REPORT: nxt_st[g] = ST_REPORT;
              ACT_NONE: ;
            endcase
          end
        end
        ST_LATCHED, ST_REPORT: begin
          if (!cond[g] && clear_fault_cmd) nxt_st[g] = ST_IDLE;
        end
        ST_RETRY: begin
          if (rcnt_ff[g] + 32'h1 >= retry_len) nxt_st[g] = ST_IDLE;
          else nxt_rcnt[g] = rcnt_ff[g] + 32'h1;
        end
      endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_ff[g] <= ST_IDLE;
        rcnt_ff[g] <= '0;
      end else begin
        st_ff[g] <= nxt_st[g];
        rcnt_ff[g] <= nxt_rcnt[g];
      end
    end

    assign flag[g] = (st_ff[g] != ST_IDLE);
    assign brake[g] = (st_ff[g] == ST_LATCHED || st_ff[g] == ST_RETRY) &&
                      mode[g][MODE_BRAKE_BIT];
    assign off[g] = (st_ff[g] == ST_LATCHED || st_ff[g] == ST_RETRY) &&
                    !mode[g][MODE_BRAKE_BIT];
  end

  // Which stall conditions were seen, held with the stall flag.
  logic [2:0] cause_ff, nxt_cause;
  always_comb begin
    nxt_cause = cause_ff;
    // Cause bits drop on the same edge as the stall flag, also at retry expiry.
    if (nxt_st[1] == ST_IDLE) nxt_cause = '0;
    if (st_ff[1] == ST_IDLE && nxt_st[1] != ST_IDLE) begin
      nxt_cause = {open_phase_detect, backemf_mismatch_detect, overspeed_detect};
    end
  end

  // ==========================================================
  // Outputs: gates, fault pin, read data.
  logic [2:0] nxt_hs, nxt_ls;
  logic       nxt_fault_n;
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_hs = gate_hs_req;
    nxt_ls = gate_ls_req;
    if (|off) begin
      nxt_hs = '0;  // All transistors off.
      nxt_ls = '0;
    end else if (|brake) begin
      nxt_hs = '0;  // Low sides on.
      nxt_ls = '1;
    end
    nxt_fault_n = !(|flag || pebf_ff);
    nxt_rdata = '0;
    unique case (paddr)
      OFS_CTRL: nxt_rdata = ctrl_ff;
      OFS_THR0: nxt_rdata = thr0_ff;
      OFS_THR1: nxt_rdata = thr1_ff;
      OFS_STATUS: nxt_rdata = {25'h0, param_est_backemf_fault, cause_ff, flag[1], flag[0],
                               |flag};
      default: nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_ff <= '0;
      gate_hs <= '0;
      gate_ls <= '0;
      fault_out_n <= 1'b1;
      prdata <= '0;
    end else begin
      cause_ff <= nxt_cause;
      gate_hs <= nxt_hs;
      gate_ls <= nxt_ls;
      fault_out_n <= nxt_fault_n;
      prdata <= nxt_rdata;
    end
  end

  // ==========================================================
  // Checks.
  a_off_gates: assert property (@(posedge pclk) disable iff (!presetn)
    off[0] |=> (gate_hs == 3'h0 && gate_ls == 3'h0)) else $error("gates not off");
  a_brake_ls: assert property (@(posedge pclk) disable iff (!presetn)
    (brake[0] && !off[1]) |=> gate_ls == 3'h7) else $error("low sides not on");
  a_pin_low: assert property (@(posedge pclk) disable iff (!presetn)
    flag[0] |=> !fault_out_n) else $error("fault pin not low");
  a_ignore_odd: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff[0] == ST_IDLE && mode[0][3] && mode[0][0]) |=> st_ff[0] == ST_IDLE)
    else $error("disabled mode acted");
  a_report_run: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff[1] == ST_REPORT && st_ff[0] == ST_IDLE) |=> gate_hs == $past(gate_hs_req))
    else $error("report stopped gates");
  a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff[1] == ST_LATCHED && !clear_fault_cmd) |=> st_ff[1] == ST_LATCHED)
    else $error("latched fault released");
  a_retry_end: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff[1] == ST_RETRY && rcnt_ff[1] + 32'h1 >= retry_len) |=> !flag[1])
    else $error("retry not expired");
  a_stall_take: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff[1] == ST_IDLE && stall_event && stall_response_sel == 4'h0) |=> st_ff[1] == ST_LATCHED)
    else $error("stall missed");
  a_mpet_set: assert property (@(posedge pclk) disable iff (!presetn)
    (param_est_active && backemf_measured < backemf_measure_threshold) |=> pebf_ff)
    else $error("measure fault missed");
  c_latch: cover property (@(posedge pclk) st_ff[0] == ST_LATCHED);
  c_retry: cover property (@(posedge pclk) st_ff[1] == ST_RETRY ##1 st_ff[1] == ST_IDLE);
  c_report: cover property (@(posedge pclk) st_ff[1] == ST_REPORT);
  c_brake: cover property (@(posedge pclk) st_ff[1] == ST_LATCHED && brake[1]);
  c_measure: cover property (@(posedge pclk) $rose(pebf_ff));

endmodule

/* File: testbench.sv */
// Self-checking bench for the lock fault responder.
// Assumes the responder, its package and the half-bridge model.
`timescale 1ns/1ps
module testbench;
  import lock_fault_pkg::*;
  // ==========================================================
  // Signals.
  localparam logic [2:0] HS = 3'h1;  // Commanded high sides.
  localparam logic [2:0] LS = 3'h2;  // Commanded low sides.
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        oc, open_loop, running, pe_act, fault_out_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, ctl;
  logic [15:0] spd, b_est, b_exp, b_meas;
  logic [2:0]  ph_low, hs_req, ls_req, gate_hs, gate_ls;
  int          miscompares, num_checks, shoot_cnt;
  // Short counts keep the run brief.
  lock_fault_responder #(.OPEN_CYC(8), .RETRY_CYC(6)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .overcurrent_event(oc),
    .speed_meas(spd), .backemf_est(b_est), .backemf_expected(b_exp),
    .phase_current_low(ph_low), .open_loop(open_loop), .motor_running(running),
    .param_est_active(pe_act), .backemf_measured(b_meas),
    .gate_hs_req(hs_req), .gate_ls_req(ls_req), .gate_hs(gate_hs),
    .gate_ls(gate_ls), .fault_out_n(fault_out_n));
  half_bridge_model #(.HS_CMD(HS), .LS_CMD(LS)) bridge (
    .pclk(pclk), .presetn(presetn), .gate_hs(gate_hs), .gate_ls(gate_ls),
    .gate_hs_req(hs_req), .gate_ls_req(ls_req), .shoot_cnt(shoot_cnt));
  // ==========================================================
  // Shared tasks.
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    chk("pready", 1, pready);
    chk("pslverr", 0, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Outputs are looked at mid-cycle; the task returns on a rising edge.
  task automatic chk_out(input logic [2:0] h, input logic [2:0] l, input logic f);
    @(negedge pclk);
    chk("gate_hs", h, gate_hs);
    chk("gate_ls", l, gate_ls);
    chk("fault_out_n", f, fault_out_n);
    @(posedge pclk);
  endtask
  task automatic chk_st(input logic [31:0] e);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", e, rd);
  endtask
  task automatic wctl(input logic [3:0] om, input logic [3:0] sm, input logic [2:0] en);
    ctl = {16'h0, 4'h1, 1'b0, en, sm, om};
    apb(1'b1, OFS_CTRL, ctl);
  endtask
  task automatic clr;
    apb(1'b1, OFS_CTRL, ctl | 32'h8000_0000);
  endtask
  // ==========================================================
  // Scenarios.
  task automatic t_regs;
    chk_st(32'h0);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", CTRL_RESET, rd);
    apb(1'b1, OFS_THR0, 32'h0014_03E8);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    apb(1'b0, OFS_THR0, 32'h0);
    chk("thr0", 32'h0014_03E8, rd);
    $display("done t_regs");
  endtask
  task automatic t_oc_latch;
    for (int i = 0; i < 2; i++) begin
      wctl(4'(2 * i), 4'h9, 3'h0);
      oc <= 1'b1;
      cyc(4);
      chk_out(3'h0, i ? 3'h7 : 3'h0, 1'b0);
      chk_st(32'h3);
      clr();
      cyc(3);
      chk_out(3'h0, i ? 3'h7 : 3'h0, 1'b0);
      oc <= 1'b0;
      cyc(3);
      chk_out(3'h0, i ? 3'h7 : 3'h0, 1'b0);
      clr();
      cyc(4);
      chk_out(HS, LS, 1'b1);
    end
    $display("done t_oc_latch");
  endtask
  task automatic t_oc_retry;
    for (int i = 0; i < 2; i++) begin
      wctl(4'(4 + 2 * i), 4'h9, 3'h0);
      oc <= 1'b1;
      cyc(4);
      chk_out(3'h0, i ? 3'h7 : 3'h0, 1'b0);
      chk_st(32'h3);
      cyc(1);
      oc <= 1'b0;
      chk_out(3'h0, i ? 3'h7 : 3'h0, 1'b0);
      cyc(16);
      chk_out(HS, LS, 1'b1);
      chk_st(32'h0);
    end
    $display("done t_oc_retry");
  endtask
  task automatic t_oc_report;
    wctl(MODE_REPORT, 4'h9, 3'h0);
    oc <= 1'b1;
    cyc(4);
    chk_out(HS, LS, 1'b0);
    chk_st(32'h3);
    cyc(1);
    oc <= 1'b0;
    clr();
    cyc(4);
    chk_out(HS, LS, 1'b1);
    chk_st(32'h0);
    $display("done t_oc_report");
  endtask
  task automatic t_oc_off;
    logic [3:0] m [7] = '{4'h9, 4'hB, 4'hD, 4'hF, 4'hA, 4'hC, 4'hE};
    foreach (m[i]) begin
      wctl(m[i], 4'h9, 3'h0);
      oc <= 1'b1;
      cyc(4);
      chk_out(HS, LS, 1'b1);
      chk_st(32'h0);
      cyc(1);
      oc <= 1'b0;
    end
    $display("done t_oc_off");
  endtask
  task automatic t_stall_latch;
    running <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wctl(4'h9, 4'(2 * i), 3'h0);
      spd <= 16'd2000;
      cyc(4);
      chk_out(HS, LS, 1'b1);
      wctl(4'h9, 4'(2 * i), 3'h1);
      cyc(4);
      chk_out(3'h0, i ? 3'h7 : 3'h0, 1'b0);
      chk_st(32'hD);
      cyc(1);
      spd <= 16'd100;
      clr();
      cyc(4);
      chk_out(HS, LS, 1'b1);
    end
    $display("done t_stall_latch");
  endtask
  task automatic t_stall_retry;
    for (int i = 0; i < 2; i++) begin
      wctl(4'h9, 4'(4 + 2 * i), 3'h2);
      b_est <= 16'd100;
      cyc(4);
      chk_out(3'h0, i ? 3'h7 : 3'h0, 1'b0);
      chk_st(32'h15);
      cyc(1);
      b_est <= 16'd10;
      cyc(16);
      chk_out(HS, LS, 1'b1);
      chk_st(32'h0);
    end
    $display("done t_stall_retry");
  endtask
  task automatic t_open_report;
    wctl(4'h9, MODE_REPORT, 3'h4);
    open_loop <= 1'b1;
    ph_low <= 3'h2;
    cyc(4);
    chk_out(HS, LS, 1'b1);
    cyc(8);
    chk_out(HS, LS, 1'b0);
    chk_st(32'h25);
    cyc(1);
    ph_low <= 3'h0;
    clr();
    cyc(4);
    chk_out(HS, LS, 1'b1);
    $display("done t_open_report");
  endtask
  task automatic t_stall_off;
    wctl(4'h9, 4'h9, 3'h1);
    spd <= 16'd2000;
    cyc(4);
    chk_out(HS, LS, 1'b1);
    chk_st(32'h0);
    spd <= 16'd100;
    $display("done t_stall_off");
  endtask
  task automatic t_param;
    apb(1'b1, OFS_THR1, 32'h0032_0000);
    pe_act <= 1'b1;
    b_meas <= 16'd5;
    cyc(4);
    chk_st(32'h40);
    chk_out(HS, LS, 1'b0);
    $display("done t_param");
  endtask
  // ==========================================================
  // Verdict, reached from the main sequence and from the watchdog.
  task automatic test_done;
    chk("shoot_through", 0, shoot_cnt);
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Clock at 25 MHz.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Watchdog well beyond the expected run length.
  initial begin
    #(40 * 5000);
    miscompares++;
    test_done();
  end
  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, oc, open_loop, running, pe_act} = 8'h0;
    {paddr, pwdata, ctl} = '0;
    {spd, b_est, b_exp, b_meas, ph_low} = {16'd100, 16'd10, 16'd10, 16'd100, 3'h0};
    num_checks = 0;
    miscompares = 0;
    cyc(10);
    presetn <= 1'b1;
    t_regs();
    t_oc_latch();
    t_oc_retry();
    t_oc_report();
    t_oc_off();
    t_stall_latch();
    t_stall_retry();
    t_open_report();
    t_stall_off();
    t_param();
    test_done();
  end
endmodule
